// [rtl/oscpll_ctrl.sv]
/*
  Oscillator source and system PLL controller: secondary oscillator
  enable and warm-up, fast RC postscaler and tuning, low-power RC keep
  alive, PLL multiplier, divider and lock status, key-protected writes.
  Assumes an Avalon-MM master, static configuration words, and a
  power-up timer flag on the core clock.
*/
// The Avalon-MM register port and the placing of the registers were decided locally.
// Notes on behaviour
// [R1] Secondary oscillator needs hardware enable and software bit.
// [R2] Enabled secondary oscillator owns both crystal pins.
// [R3] Control writes need key one then key two.
// [R4] Warm-up counts 1024 cycles, then sets ready bit.
// [R5] Fast RC postscaler divides by 1 to 256.
// [R6] Current code 111 selects postscaled fast RC.
// [R7] Code 001 feeds fast RC, input divider forced.
// [R8] Each tuning step shifts fast RC by one step.
// [R9] Tuning writes need the same key sequence.
// [R10] Low-power RC runs at power-on when regulator enabled.
// [R11] After power-up timer, low-power RC runs only if needed.
// [R12] PLL reference is primary oscillator or fast RC.
// [R13] Reset copies configured multiplier and divider into control.
// [R14] Multiplier and divider writable; input divider fixed.
// [R15] Lock bit drops on input change, sets on lock/timeout.
// [R16] Lock bit clear at reset and on non-PLL sources.
// [R17] Multiplier codes map to 15..21 and 24.
// [R18] Divider codes map to 1..64 and 256.
// [R19] Configuration keeps PLL input between 4 and 5 MHz.
// [R20] Switch to crystal or PLL waits the start-up delay.
// [R21] Disabling secondary oscillator clears ready and counter.
`timescale 1ns/1ps
`default_nettype none

module oscpll_ctrl
  import oscpll_pkg::*;
#(
  parameter int OST_CYCLES       = 1024,
  parameter int PLL_START_CYCLES = 1024
) (
  input  wire logic              CORE_CLK_I,
  input  wire logic              RESET_N_I,
  input  wire logic [ADDR_W-1:0] AVS_ADDRESS_I,
  input  wire logic              AVS_READ_I,
  input  wire logic              AVS_WRITE_I,
  input  wire logic [31:0]       AVS_WRITEDATA_I,
  input  wire logic [3:0]        AVS_BYTEENABLE_I,
  output logic      [31:0]       AVS_READDATA_O,
  output logic                   AVS_WAITREQUEST_O,
  input  wire oscpll_cfg_t       CFG_I,
  input  wire logic              POWER_UP_TIMER_DONE_I,
  input  wire logic              SOSC_CLK_I,
  input  wire logic              PLL_LOCK_I,
  output logic                   SOSC_EN_O,
  output logic                   SOSC_PINS_OWNED_O,
  output logic      [FLD_W-1:0]  SYSCLK_SEL_O,
  output logic                   SWITCH_BUSY_O,
  output logic                   FRC_POST_ACTIVE_O,
  output logic      [8:0]        FRC_DIV_RATIO_O,
  output logic      [TUNE_W-1:0] FRC_TUNE_O,
  output logic                   LOW_POWER_RC_EN_O,
  output logic                   PLL_REF_FRC_O,
  output logic      [FLD_W-1:0]  PLL_IDIV_CODE_O,
  output logic                   PLL_IDIV_FORCE2_O,
  output logic      [4:0]        PLL_MULT_O,
  output logic      [8:0]        PLL_ODIV_O,
  output logic                   PLL_LOCK_O
);

  localparam logic [CNT_W-1:0] OST_LAST = CNT_W'(OST_CYCLES - 1);
  localparam logic [CNT_W-1:0] PLL_LAST = CNT_W'(PLL_START_CYCLES - 1);

  typedef struct packed {
    oscpll_key_t       key;
    oscpll_sw_t        sw;
    logic              init;
    logic              ack;
    logic [31:0]       rdata;
    logic              sosc_sw;
    logic [FLD_W-1:0]  nosc;
    logic [FLD_W-1:0]  current_osc_field;
    logic [FLD_W-1:0]  fast_rc_postscale_field;
    logic [FLD_W-1:0]  mult;
    logic [FLD_W-1:0]  odiv;
    logic [TUNE_W-1:0] tune;
    logic [WARM_W-1:0] wcnt;
    logic              rdy;
    logic [2:0]        sosc_sync;
    logic              sosc_lvl;
    logic [2:0]        lock_sync;
    logic              lock_lvl;
    logic              lock;
    logic [CNT_W-1:0]  pllcnt;
    logic [CNT_W-1:0]  ost;
  } oscpll_state_t;

  oscpll_state_t s_q;
  oscpll_state_t s_d;

  logic        wr_ok;
  logic        unlocked;
  logic        sosc_on;
  logic        sosc_rise;
  logic        lock_agree;
  logic [31:0] ctrl_rd;
  logic [31:0] stat_rd;
  logic [31:0] wv;
  logic [31:0] tv;

  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0]  be);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[8*i +: 8] = new_v[8*i +: 8];
      end
    end
    merge = r;
  endfunction : merge

  function automatic logic needs_delay(input logic [FLD_W-1:0] c,
                                       input logic            xtal);
    needs_delay = uses_pll(c) || ((c == OSC_PRI) && xtal);
  endfunction : needs_delay

  assign unlocked   = (s_q.key == KEY_OPEN);
  assign wr_ok      = AVS_WRITE_I && s_q.ack;
  assign sosc_on    = CFG_I.sosc_hw_en && s_q.sosc_sw;  // see [R1]
  assign sosc_rise  = (s_q.sosc_sync[1] == s_q.sosc_sync[2]) &&
                      s_q.sosc_sync[2] && !s_q.sosc_lvl;
  assign lock_agree = (s_q.lock_sync[1] == s_q.lock_sync[2]);

  always_comb begin
    ctrl_rd                        = '0;
    ctrl_rd[B_SWITCH]              = (s_q.sw == SW_WAIT);
    ctrl_rd[B_SOSC_SW]             = s_q.sosc_sw;
    ctrl_rd[B_LOCK]                = s_q.lock;
    ctrl_rd[NOSC_LO +: FLD_W]      = s_q.nosc;
    ctrl_rd[CURRENT_OSC_FIELD_LO +: FLD_W]      = s_q.current_osc_field;
    ctrl_rd[MULT_LO +: FLD_W]      = s_q.mult;
    ctrl_rd[B_RDY]                 = s_q.rdy;
    ctrl_rd[FAST_RC_POSTSCALE_FIELD_LO +: FLD_W]    = s_q.fast_rc_postscale_field;
    ctrl_rd[ODIV_LO +: FLD_W]      = s_q.odiv;
    stat_rd                        = '0;
    stat_rd[S_UNLOCK]              = unlocked;
    stat_rd[S_BUSY]                = (s_q.sw == SW_WAIT);
    stat_rd[S_LOW_POWER_RC]                = LOW_POWER_RC_EN_O;
    stat_rd[S_SOSC]                = sosc_on;
  end

  always_comb begin
    s_d = s_q;
    wv  = merge(ctrl_rd, AVS_WRITEDATA_I, AVS_BYTEENABLE_I);
    tv  = merge({{(32-TUNE_W){1'b0}}, s_q.tune}, AVS_WRITEDATA_I, AVS_BYTEENABLE_I);

    // Bus answer: one wait cycle, read data latched meanwhile.
    s_d.ack = (AVS_READ_I || AVS_WRITE_I) && !s_q.ack;
    if (AVS_READ_I && !s_q.ack) begin
      case (AVS_ADDRESS_I)
        OFS_CTRL: s_d.rdata = ctrl_rd;
        OFS_TUNE: s_d.rdata = {{(32-TUNE_W){1'b0}}, s_q.tune};
        OFS_STAT: s_d.rdata = stat_rd;
        default:  s_d.rdata = '0;
      endcase
    end

    // Pin synchronisers; a level counts once stages two and three agree.
    s_d.sosc_sync = {s_q.sosc_sync[1:0], SOSC_CLK_I};
    s_d.lock_sync = {s_q.lock_sync[1:0], PLL_LOCK_I};
    if (s_q.sosc_sync[1] == s_q.sosc_sync[2]) begin
      s_d.sosc_lvl = s_q.sosc_sync[2];
    end
    if (lock_agree) begin
      s_d.lock_lvl = s_q.lock_sync[2];
    end

    // Secondary oscillator warm-up.
    if (!sosc_on) begin
      s_d.wcnt = '0;                                    // see [R21]
      s_d.rdy  = 1'b0;                                  // see [R21]
    end else if (sosc_rise && !s_q.rdy) begin
      s_d.wcnt = WARM_W'(s_q.wcnt + 1'b1);              // see [R4]
      if (s_q.wcnt == WARM_W'(SOSC_WARM - 1'b1)) begin
        s_d.rdy = 1'b1;                                 // see [R4]
      end
    end

    // PLL lock status follows lock or start-up timeout.
    if (uses_pll(s_q.current_osc_field)) begin
      if (!s_q.lock) begin
        if (s_q.lock_lvl || (s_q.pllcnt == PLL_LAST)) begin
          s_d.lock = 1'b1;                              // see [R15]
        end else begin
          s_d.pllcnt = CNT_W'(s_q.pllcnt + 1'b1);
        end
      end
    end else begin
      s_d.lock   = 1'b0;                                // see [R16]
      s_d.pllcnt = '0;
    end

    // Clock switch start-up delay.
    case (s_q.sw)
      SW_IDLE: begin
        s_d.ost = '0;
      end
      SW_WAIT: begin
        s_d.ost = CNT_W'(s_q.ost + 1'b1);
        if (s_q.ost == OST_LAST) begin
          s_d.sw   = SW_IDLE;
          s_d.current_osc_field = s_q.nosc;                          // see [R20]
          s_d.lock = 1'b0;                              // see [R15]
          s_d.pllcnt = '0;
        end
      end
      default: begin
        s_d.sw = SW_IDLE;
      end
    endcase

    // Register writes; protected ones only while the keys are open.
    if (wr_ok && (AVS_ADDRESS_I == OFS_KEY)) begin
      if ((AVS_BYTEENABLE_I == BE_ALL) && (AVS_WRITEDATA_I == KEY_ONE)) begin
        s_d.key = KEY_HALF;                             // see [R3]
      end else if ((AVS_BYTEENABLE_I == BE_ALL) && (s_q.key == KEY_HALF) &&
                   (AVS_WRITEDATA_I == KEY_TWO)) begin
        s_d.key = KEY_OPEN;                             // see [R3]
      end else begin
        s_d.key = KEY_LOCKED;                           // see [R3]
      end
    end
    if (wr_ok && unlocked && (AVS_ADDRESS_I == OFS_CTRL)) begin  // see [R3]
      s_d.sosc_sw = wv[B_SOSC_SW];                      // see [R1]
      s_d.fast_rc_postscale_field  = wv[FAST_RC_POSTSCALE_FIELD_LO +: FLD_W];             // see [R5]
      s_d.mult    = wv[MULT_LO +: FLD_W];               // see [R14]
      s_d.odiv    = wv[ODIV_LO +: FLD_W];               // see [R14]
      if (s_q.sw == SW_IDLE) begin
        s_d.nosc = wv[NOSC_LO +: FLD_W];
        if (wv[B_SWITCH] && AVS_WRITEDATA_I[B_SWITCH]) begin
          if (needs_delay(wv[NOSC_LO +: FLD_W], CFG_I.posc_xtal)) begin
            s_d.sw = SW_WAIT;                           // see [R20]
          end else begin
            s_d.current_osc_field = wv[NOSC_LO +: FLD_W];
          end
        end
      end
    end
    if (wr_ok && unlocked && (AVS_ADDRESS_I == OFS_TUNE)) begin  // see [R9]
      s_d.tune = tv[TUNE_W-1:0];
    end

    // First edge after reset loads the configuration words.
    if (s_q.init) begin
      s_d.init   = 1'b0;
      s_d.mult   = CFG_I.pll_mult;                      // see [R13]
      s_d.odiv   = CFG_I.pll_odiv;                      // see [R13]
      s_d.current_osc_field   = CFG_I.init_osc;
      s_d.nosc   = CFG_I.init_osc;
      s_d.lock   = 1'b0;
      s_d.pllcnt = '0;
    end
  end

  always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      s_q      <= '0;
      s_q.init <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign AVS_WAITREQUEST_O = (AVS_READ_I || AVS_WRITE_I) && !s_q.ack;
  assign AVS_READDATA_O    = s_q.rdata;
  assign SOSC_EN_O         = sosc_on;                   // see [R1]
  assign SOSC_PINS_OWNED_O = sosc_on;                   // see [R2]
  assign SYSCLK_SEL_O      = s_q.current_osc_field;
  assign SWITCH_BUSY_O     = (s_q.sw == SW_WAIT);
  assign FRC_POST_ACTIVE_O = (s_q.current_osc_field == OSC_FAST_RC_POSTSCALE_FIELD);  // see [R6]
  assign FRC_DIV_RATIO_O   = div_ratio(s_q.fast_rc_postscale_field);     // see [R5]
  assign FRC_TUNE_O        = s_q.tune;                  // see [R8]
  assign LOW_POWER_RC_EN_O         = POWER_UP_TIMER_DONE_I ?
                             (CFG_I.fail_safe_clock_monitor_en || CFG_I.wdt_en ||
                              (s_q.current_osc_field == LOW_POWER_RC_SYS_CODE)) :  // see [R11]
                             CFG_I.vreg_en;             // see [R10]
  assign PLL_REF_FRC_O     = (s_q.current_osc_field == OSC_FAST_RC_WITH_PLL_MODE);  // see [R12]
  assign PLL_IDIV_CODE_O   = CFG_I.pll_idiv;            // see [R14]
  assign PLL_IDIV_FORCE2_O = (s_q.current_osc_field == OSC_FAST_RC_WITH_PLL_MODE);  // see [R7]
  assign PLL_MULT_O        = mult_factor(s_q.mult);     // see [R17]
  assign PLL_ODIV_O        = div_ratio(s_q.odiv);       // see [R18]
  assign PLL_LOCK_O        = s_q.lock;

  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (!RESET_N_I);

  sosc_gate_a: assert property (SOSC_EN_O |-> CFG_I.sosc_hw_en && s_q.sosc_sw)  // see [R1]
    else $error("Secondary oscillator on without both enables.");
  pin_own_a: assert property (SOSC_PINS_OWNED_O == SOSC_EN_O)  // see [R2]
    else $error("Crystal pin ownership differs from oscillator enable.");
  key_guard_a: assert property ((wr_ok && !unlocked && !s_q.init &&  // see [R3]
      AVS_ADDRESS_I == OFS_CTRL) |=> $stable(s_q.mult) && $stable(s_q.sosc_sw))
    else $error("Control register changed while locked.");
  warm_done_a: assert property ($rose(s_q.rdy) |-> s_q.wcnt == SOSC_WARM)  // see [R4]
    else $error("Ready bit set at wrong warm-up count.");
  frc_div_a: assert property (s_q.fast_rc_postscale_field == 3'h7 |-> FRC_DIV_RATIO_O == DIV_MAX)  // see [R5]
    else $error("Top postscaler code is not divide by 256.");
  frc_mode_a: assert property (FRC_POST_ACTIVE_O == (SYSCLK_SEL_O == OSC_FAST_RC_POSTSCALE_FIELD))  // see [R6]
    else $error("Postscaler mode does not follow current source.");
  idiv_force_a: assert property (SYSCLK_SEL_O == OSC_FAST_RC_WITH_PLL_MODE |->  // see [R7]
      PLL_IDIV_FORCE2_O && PLL_REF_FRC_O)
    else $error("Fast RC PLL mode without forced input divider.");
  tune_guard_a: assert property ((wr_ok && !unlocked &&  // see [R9]
      AVS_ADDRESS_I == OFS_TUNE) |=> $stable(FRC_TUNE_O))
    else $error("Tuning changed while locked.");
  low_power_rc_stop_a: assert property ((POWER_UP_TIMER_DONE_I && !CFG_I.wdt_en && !CFG_I.fail_safe_clock_monitor_en &&  // see [R11]
      SYSCLK_SEL_O != LOW_POWER_RC_SYS_CODE) |-> !LOW_POWER_RC_EN_O)
    else $error("Low-power RC left running without a user.");
  init_copy_a: assert property ($fell(s_q.init) |->  // see [R13]
      s_q.mult == CFG_I.pll_mult && s_q.odiv == CFG_I.pll_odiv)
    else $error("Reset copy of PLL fields is wrong.");
  lock_clear_a: assert property (!uses_pll(s_q.current_osc_field) |=>  // see [R16]
      !uses_pll(s_q.current_osc_field) |-> !PLL_LOCK_O)
    else $error("Lock bit set on a non-PLL source.");
  lock_timer_a: assert property (s_q.pllcnt <= PLL_LAST)  // see [R15]
    else $error("PLL start-up timer ran past its limit.");
  ost_wait_a: assert property ((s_q.sw == SW_WAIT && s_q.ost == OST_LAST) |=>  // see [R20]
      SYSCLK_SEL_O == $past(s_q.nosc) && s_q.sw == SW_IDLE)
    else $error("Delayed switch did not commit at the end of the delay.");
  warm_clear_a: assert property (!SOSC_EN_O |=> !s_q.rdy || SOSC_EN_O)  // see [R21]
    else $error("Ready bit survived oscillator disable.");

endmodule : oscpll_ctrl

`default_nettype wire

// [rtl/oscpll_pkg.sv]
/*
  Constants, field layout, state types and decode functions of the
  oscillator source and system PLL controller.
  Assumes a 32-bit register bus with byte addresses.
*/
package oscpll_pkg;

  localparam int ADDR_W = 5;
  localparam int CNT_W  = 16;
  localparam int FLD_W  = 3;
  localparam int TUNE_W = 6;
  localparam int WARM_W = 11;

  localparam logic [ADDR_W-1:0] OFS_CTRL = 5'h00;
  localparam logic [ADDR_W-1:0] OFS_TUNE = 5'h04;
  localparam logic [ADDR_W-1:0] OFS_KEY  = 5'h08;
  localparam logic [ADDR_W-1:0] OFS_STAT = 5'h0c;

  localparam logic [31:0] KEY_ONE  = 32'haa996655;
  localparam logic [31:0] KEY_TWO  = 32'h556699aa;
  localparam logic [3:0]  BE_ALL   = 4'hf;

  localparam int B_SWITCH  = 0;
  localparam int B_SOSC_SW = 1;
  localparam int B_LOCK    = 5;
  localparam int NOSC_LO   = 8;
  localparam int CURRENT_OSC_FIELD_LO   = 12;
  localparam int MULT_LO   = 16;
  localparam int B_RDY     = 22;
  localparam int FAST_RC_POSTSCALE_FIELD_LO = 24;
  localparam int ODIV_LO   = 27;

  localparam int S_UNLOCK = 0;
  localparam int S_BUSY   = 1;
  localparam int S_LOW_POWER_RC   = 2;
  localparam int S_SOSC   = 3;

  localparam logic [FLD_W-1:0] OSC_FAST_RC_WITH_PLL_MODE    = 3'h1;
  localparam logic [FLD_W-1:0] OSC_PRI       = 3'h2;
  localparam logic [FLD_W-1:0] OSC_PRIPLL    = 3'h3;
  localparam logic [FLD_W-1:0] LOW_POWER_RC_SYS_CODE = 3'h4;
  localparam logic [FLD_W-1:0] OSC_FAST_RC_POSTSCALE_FIELD    = 3'h7;

  localparam logic [WARM_W-1:0] SOSC_WARM = 11'h400;
  localparam logic [8:0]        DIV_MAX   = 9'h100;

  typedef enum logic [1:0] {
    KEY_LOCKED = 2'h0,
    KEY_HALF   = 2'h1,
    KEY_OPEN   = 2'h3
  } oscpll_key_t;

  typedef enum logic {
    SW_IDLE = 1'h0,
    SW_WAIT = 1'h1
  } oscpll_sw_t;

  typedef struct packed {
    logic             sosc_hw_en;
    logic             posc_xtal;
    logic [FLD_W-1:0] init_osc;
    logic [FLD_W-1:0] pll_idiv;
    logic [FLD_W-1:0] pll_mult;
    logic [FLD_W-1:0] pll_odiv;
    logic             wdt_en;
    logic             fail_safe_clock_monitor_en;
    logic             vreg_en;
  } oscpll_cfg_t;

  // Multiplier codes 0..7 give 15..21 and then 24.
  function automatic logic [4:0] mult_factor(input logic [FLD_W-1:0] c);
    mult_factor = (c == 3'h7) ? 5'h18 : 5'(5'h0f + {2'h0, c});
  endfunction : mult_factor

  // Divider codes 0..6 give powers of two, code 7 gives 256.
  function automatic logic [8:0] div_ratio(input logic [FLD_W-1:0] c);
    div_ratio = (c == 3'h7) ? DIV_MAX : 9'(9'h001 << c);
  endfunction : div_ratio

  function automatic logic uses_pll(input logic [FLD_W-1:0] c);
    uses_pll = (c == OSC_FAST_RC_WITH_PLL_MODE) || (c == OSC_PRIPLL);
  endfunction : uses_pll

endpackage : oscpll_pkg

// [verification/oscpll_ctrl_tb.sv]
/*
  Self-checking testbench of the oscillator source and PLL controller.
  Assumes the design package and a design that answers each bus request
  after one wait cycle; start-up counts are shortened by parameters.
*/
`timescale 1ns/1ps
`default_nettype none

`define CHK(what, exp, got) begin check_count++; if ((got) !== (exp)) begin bad_count++; \
  $display("ERROR %s expected %0h seen %0h", what, exp, got); end end

module oscpll_ctrl_tb;
  import oscpll_pkg::*;

  localparam int OST = 8;
  localparam int PST = 8;

  logic              core_clk;
  logic              reset_n;
  logic [ADDR_W-1:0] avs_address;
  logic              avs_read;
  logic              avs_write;
  logic [31:0]       avs_wdata;
  logic [31:0]       avs_rdata;
  logic              avs_waitreq;
  oscpll_cfg_t       cfg;
  logic              power_up_timer_done;
  logic              sosc_clk;
  logic              pll_lock_in;
  logic              sosc_en;
  logic              sosc_pins;
  logic [FLD_W-1:0]  sysclk_sel;
  logic              switch_busy;
  logic              frc_post;
  logic [8:0]        frc_ratio;
  logic [TUNE_W-1:0] frc_tune;
  logic              low_power_rc_en;
  logic              ref_frc;
  logic [FLD_W-1:0]  idiv_code;
  logic              idiv_force2;
  logic [4:0]        pll_mult;
  logic [8:0]        pll_odiv;
  logic              pll_lock;
  int                bad_count;
  int                check_count;
  logic [31:0]       q;
  logic [4:0]        mtab [8] = '{5'h0f, 5'h10, 5'h11, 5'h12, 5'h13, 5'h14, 5'h15, 5'h18};
  logic [8:0]        dtab [8] = '{9'h001, 9'h002, 9'h004, 9'h008, 9'h010, 9'h020, 9'h040, 9'h100};

  oscpll_ctrl #(.OST_CYCLES(OST), .PLL_START_CYCLES(PST)) u_dut (
    .CORE_CLK_I(core_clk), .RESET_N_I(reset_n), .AVS_ADDRESS_I(avs_address),
    .AVS_READ_I(avs_read), .AVS_WRITE_I(avs_write), .AVS_WRITEDATA_I(avs_wdata),
    .AVS_BYTEENABLE_I(BE_ALL), .AVS_READDATA_O(avs_rdata), .AVS_WAITREQUEST_O(avs_waitreq),
    .CFG_I(cfg), .POWER_UP_TIMER_DONE_I(power_up_timer_done), .SOSC_CLK_I(sosc_clk), .PLL_LOCK_I(pll_lock_in),
    .SOSC_EN_O(sosc_en), .SOSC_PINS_OWNED_O(sosc_pins), .SYSCLK_SEL_O(sysclk_sel),
    .SWITCH_BUSY_O(switch_busy), .FRC_POST_ACTIVE_O(frc_post), .FRC_DIV_RATIO_O(frc_ratio),
    .FRC_TUNE_O(frc_tune), .LOW_POWER_RC_EN_O(low_power_rc_en), .PLL_REF_FRC_O(ref_frc),
    .PLL_IDIV_CODE_O(idiv_code), .PLL_IDIV_FORCE2_O(idiv_force2), .PLL_MULT_O(pll_mult),
    .PLL_ODIV_O(pll_odiv), .PLL_LOCK_O(pll_lock)
  );

  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  task automatic final_report;
    $display("Checks %0d, mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : final_report

  // One bus cycle; the request is held until waitrequest is seen low.
  task automatic bus(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    avs_address <= a;
    avs_read    <= !wr;
    avs_write   <= wr;
    avs_wdata   <= d;
    do begin
      @(negedge core_clk);
      n++;
    end while (avs_waitreq !== 1'b0 && n < 64);
    if (n >= 64) begin
      bad_count++;
      $display("ERROR bus answer expected 0 seen 1");
    end
    @(posedge core_clk);
    q = avs_rdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
    @(negedge core_clk);
  endtask : bus

  function automatic logic [31:0] ctl(input logic [2:0] nosc, input logic sw,
                                      input logic so, input logic [2:0] m, input logic [2:0] f,
                                      input logic [2:0] o);
    ctl = (32'(o) << ODIV_LO) | (32'(f) << FAST_RC_POSTSCALE_FIELD_LO) | (32'(m) << MULT_LO) |
          (32'(nosc) << NOSC_LO) | (32'(so) << B_SOSC_SW) | 32'(sw);
  endfunction : ctl

  task automatic unlock;
    bus(1'b1, OFS_KEY, KEY_ONE);
    bus(1'b1, OFS_KEY, KEY_TWO);
  endtask : unlock

  task automatic t_reset;
    bus(1'b0, OFS_CTRL, 32'h0);
    `CHK("mult field", 3'h5, q[MULT_LO+:3])
    `CHK("odiv field", 3'h1, q[ODIV_LO+:3])
    `CHK("current osc", 3'h0, q[CURRENT_OSC_FIELD_LO+:3])
    `CHK("mult out", 5'h14, pll_mult)
    `CHK("lock", 1'b0, pll_lock)
    `CHK("idiv", 3'h1, idiv_code)
    `CHK("low_power_rc at power-on", 1'b1, low_power_rc_en)
  endtask : t_reset

  task automatic t_locked;
    bus(1'b1, OFS_KEY, KEY_ONE);
    bus(1'b1, OFS_KEY, 32'h0);
    bus(1'b1, OFS_KEY, KEY_TWO);
    bus(1'b1, OFS_CTRL, ctl(3'h0, 1'b0, 1'b0, 3'h7, 3'h0, 3'h1));
    bus(1'b1, OFS_TUNE, 32'h15);
    bus(1'b0, OFS_CTRL, 32'h0);
    `CHK("locked ctrl write", 3'h5, q[MULT_LO+:3])
    `CHK("locked tune write", 6'h00, frc_tune)
  endtask : t_locked

  task automatic t_fields;
    unlock();
    for (int i = 0; i < 8; i++) begin
      bus(1'b1, OFS_CTRL, ctl(3'h0, 1'b0, 1'b0, 3'(i), 3'(i), 3'(7 - i)));
      `CHK("mult factor", mtab[i], pll_mult)
      `CHK("odiv ratio", dtab[7-i], pll_odiv)
      `CHK("postscale ratio", dtab[i], frc_ratio)
    end
    `CHK("idiv fixed", 3'h1, idiv_code)
    bus(1'b1, OFS_TUNE, 32'h15);
    `CHK("tune", 6'h15, frc_tune)
    bus(1'b1, OFS_TUNE, 32'h16);
    `CHK("tune step", 6'h16, frc_tune)
  endtask : t_fields

  task automatic do_switch(input logic [2:0] code, input logic slow);
    int n;
    bus(1'b1, OFS_CTRL, ctl(code, 1'b1, 1'b0, 3'h5, 3'h0, 3'h1));
    `CHK("switch delay", slow, switch_busy)
    n = 0;
    while (switch_busy !== 1'b0 && n < 4 * OST) begin
      @(negedge core_clk);
      n++;
    end
    `CHK("current code", code, sysclk_sel)
  endtask : do_switch

  task automatic t_switch;
    int n;
    do_switch(3'h7, 1'b0);
    `CHK("postscale active", 1'b1, frc_post)
    do_switch(OSC_FAST_RC_WITH_PLL_MODE, 1'b1);
    `CHK("pll ref frc", 1'b1, ref_frc)
    `CHK("idiv forced", 1'b1, idiv_force2)
    n = 0;
    while (pll_lock !== 1'b1 && n < 40) begin
      @(negedge core_clk);
      n++;
    end
    `CHK("lock by timer", 1'b1, (n >= PST - 4 && n <= PST + 4))
    bus(1'b0, OFS_CTRL, 32'h0);
    `CHK("lock bit", 1'b1, q[B_LOCK])
    @(posedge core_clk);
    pll_lock_in <= 1'b1;
    do_switch(OSC_PRIPLL, 1'b1);
    `CHK("pll ref primary", 1'b0, ref_frc)
    repeat (6) @(negedge core_clk);
    `CHK("lock by pll", 1'b1, pll_lock)
    do_switch(OSC_PRI, 1'b1);
    `CHK("lock clear", 1'b0, pll_lock)
    do_switch(3'h0, 1'b0);
    `CHK("postscale idle", 1'b0, frc_post)
  endtask : t_switch

  task automatic t_low_power_rc;
    @(posedge core_clk);
    power_up_timer_done <= 1'b1;
    @(negedge core_clk);
    `CHK("low_power_rc stops", 1'b0, low_power_rc_en)
    do_switch(LOW_POWER_RC_SYS_CODE, 1'b0);
    `CHK("low_power_rc as sysclk", 1'b1, low_power_rc_en)
    do_switch(3'h0, 1'b0);
    @(posedge core_clk);
    cfg.wdt_en <= 1'b1;
    @(negedge core_clk);
    `CHK("low_power_rc for watchdog", 1'b1, low_power_rc_en)
    @(posedge core_clk);
    cfg.wdt_en  <= 1'b0;
    cfg.fail_safe_clock_monitor_en <= 1'b1;
    @(negedge core_clk);
    `CHK("low_power_rc for monitor", 1'b1, low_power_rc_en)
  endtask : t_low_power_rc

  task automatic pulses(input int n);
    repeat (n) begin
      @(posedge core_clk);
      sosc_clk <= 1'b1;
      repeat (4) @(posedge core_clk);
      sosc_clk <= 1'b0;
      repeat (3) @(posedge core_clk);
    end
    repeat (6) @(negedge core_clk);
  endtask : pulses

  task automatic t_sosc;
    bus(1'b1, OFS_CTRL, ctl(3'h0, 1'b0, 1'b1, 3'h5, 3'h0, 3'h1));
    `CHK("sosc without hw enable", 1'b0, sosc_en)
    @(posedge core_clk);
    cfg.sosc_hw_en <= 1'b1;
    @(negedge core_clk);
    `CHK("sosc enabled", 1'b1, sosc_en)
    `CHK("pins owned", 1'b1, sosc_pins)
    pulses(1023);
    bus(1'b0, OFS_CTRL, 32'h0);
    `CHK("ready early", 1'b0, q[B_RDY])
    pulses(1);
    bus(1'b0, OFS_CTRL, 32'h0);
    `CHK("ready at 1024", 1'b1, q[B_RDY])
    bus(1'b1, OFS_CTRL, ctl(3'h0, 1'b0, 1'b0, 3'h5, 3'h0, 3'h1));
    `CHK("pins released", 1'b0, sosc_pins)
    bus(1'b0, OFS_CTRL, 32'h0);
    `CHK("ready cleared", 1'b0, q[B_RDY])
    bus(1'b1, OFS_CTRL, ctl(3'h0, 1'b0, 1'b1, 3'h5, 3'h0, 3'h1));
    pulses(2);
    bus(1'b0, OFS_CTRL, 32'h0);
    `CHK("warm-up restarts", 1'b0, q[B_RDY])
  endtask : t_sosc

  initial begin
    bad_count   = 0;
    check_count = 0;
    reset_n     = 1'b0;
    avs_address = '0;
    avs_read    = 1'b0;
    avs_write   = 1'b0;
    avs_wdata   = 32'h0;
    power_up_timer_done   = 1'b0;
    sosc_clk    = 1'b0;
    pll_lock_in = 1'b0;
    // Input divider code 1 keeps the PLL input in its legal band.
    cfg         = '{sosc_hw_en: 1'b0, posc_xtal: 1'b1, init_osc: 3'h0, pll_idiv: 3'h1,
                    pll_mult: 3'h5, pll_odiv: 3'h1, wdt_en: 1'b0, fail_safe_clock_monitor_en: 1'b0,
                    vreg_en: 1'b1};
    repeat (8) @(posedge core_clk);
    reset_n <= 1'b1;
    repeat (2) @(negedge core_clk);
    t_reset();
    t_locked();
    t_fields();
    t_switch();
    t_low_power_rc();
    t_sosc();
    bus(1'b1, 5'h10, 32'hffffffff);
    bus(1'b0, 5'h10, 32'h0);
    `CHK("unmapped read", 32'h0, q)
    final_report();
  end

  initial begin
    repeat (40000) @(posedge core_clk);
    bad_count++;
    final_report();
  end

endmodule : oscpll_ctrl_tb

`default_nettype wire
